// ===== bench/dial_ctrl.sv
// Controller model driving the generator pins and the digit pin enable.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/100ps
module dial_ctrl (
  // Clock
  input wire logic clk,
  // Generator and enable pins
  output logic [3:0] gen_code_in,
  output logic latch,
  output logic genReset,
  output logic digit_out_enable_n
);
  // Idle pin levels
  initial begin
    gen_code_in = 4'h0;
    latch = 1'b0;
    genReset = 1'b0;
    digit_out_enable_n = 1'b0;
  end
  // Latch pulse of 100 ns with setup; code lines garbled once hold expires
  task automatic dial(input logic [3:0] v);
    gen_code_in = v;
    latch = 1'b1;
    repeat (25) @(negedge clk);
    latch = 1'b0;
    repeat (13) @(negedge clk);
    gen_code_in = ~v;
    // Let an edge pass so a following call never rewrites the code lines at once
    @(negedge clk);
  endtask
  // Generator reset level, held at least a pulse width
  task automatic hang(input logic v);
    genReset = v;
    repeat (25) @(negedge clk);
  endtask
  // Digit pin enable
  task automatic enable(input logic v);
    digit_out_enable_n = v;
    @(negedge clk);
  endtask
endmodule

// ===== bench/dtmf_checker.sv
// Concurrent checks on the transceiver control ports.
// Assumes a bind from the bench top; checks and run counters pause while ce is low.
`timescale 1ns/100ps
module dtmf_checker #(
  parameter int TONE_CYC = 40,
  parameter int PAUSE_CYC = 40,
  parameter int CP_ON_CYC = 40,
  parameter int CP_OFF_CYC = 40
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Receiver
  input wire logic [3:0] rowDet,
  input wire logic [3:0] colDet,
  input wire logic digit_out_enable_n,
  input wire logic [3:0] rx_code_out,
  input wire logic rxCodeOutEn_n,
  input wire logic digit_valid,
  input wire logic early_detect,
  // Generator
  input wire logic [3:0] gen_code_in,
  input wire logic latch,
  input wire logic genReset,
  input wire logic tone_out,
  input wire logic toneActive,
  input wire logic [1:0] toneRowSel,
  input wire logic [1:0] toneColSel,
  // Call progress
  input wire logic bandEnergy,
  input wire logic call_progress_out
);
  // Run lengths of pair, quiet, energy and silence
  int pairRun;
  int idleRun;
  int onRun;
  int offRun;
  // Exactly one row and one column; other mixes count as quiet
  wire logic pair = $onehot(rowDet) && $onehot(colDet);
  // One-hot to index, valid for one-hot input only
  function automatic logic [1:0] idx(input logic [3:0] v);
    return {v[3] | v[2], v[3] | v[1]};
  endfunction
  // Row and column to digit code
  function automatic logic [3:0] keyOf(input logic [1:0] r, input logic [1:0] c);
    if (c == 2'h3) return 4'hD + 4'(r);
    if (r == 2'h3) return (c == 2'h0) ? 4'hB : (c == 2'h1) ? 4'hA : 4'hC;
    return 4'(r) * 4'h3 + 4'(c) + 4'h1;
  endfunction
  // Receiver run counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pairRun <= 0;
      idleRun <= 0;
    end else if (ce) begin
      pairRun <= pair ? pairRun + 1 : 0;
      idleRun <= pair ? 0 : idleRun + 1;
    end
  end
  // Call progress run counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      onRun <= 0;
      offRun <= 0;
    end else if (ce) begin
      onRun <= bandEnergy ? onRun + 1 : 0;
      offRun <= bandEnergy ? 0 : offRun + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  // Frozen cycles prove nothing about timing, so checks stand down then
  default disable iff (!resetn || !ce);
  early_rise_a: assert property (pair |=> early_detect)
    else $error("early flag low during tone");
  early_drop_a: assert property (!pair |=> !early_detect)
    else $error("early flag high in pause");
  code_idle_a: assert property (!digit_valid |-> rx_code_out == 4'h0)
    else $error("code shown without valid");
  valid_rise_a: assert property ($rose(digit_valid) |-> pairRun >= TONE_CYC &&
    pairRun <= TONE_CYC + 2 && rx_code_out == keyOf(idx(rowDet), idx(colDet)))
    else $error("digit qualified at wrong time or code");
  valid_fall_a: assert property ($fell(digit_valid) |-> idleRun >= PAUSE_CYC &&
    idleRun <= PAUSE_CYC + 2)
    else $error("digit released at wrong time");
  pin_enable_a: assert property (rxCodeOutEn_n == digit_out_enable_n)
    else $error("digit pin enable mismatch");
  gen_start_a: assert property ($past(latch) && !latch && !genReset |=> toneActive &&
    keyOf(toneRowSel, toneColSel) == $past(gen_code_in))
    else $error("latched code not started");
  gen_quiet_a: assert property (genReset |=> !toneActive)
    else $error("generator active in reset");
  gen_hold_a: assert property ($rose(toneActive) |->
    $past(latch, 2) && !$past(latch) && !$past(genReset))
    else $error("generator started without latch");
  tone_off_a: assert property (!toneActive [*2] |-> !tone_out)
    else $error("tone output while silent");
  cp_rise_a: assert property ($rose(call_progress_out) |-> onRun >= CP_ON_CYC &&
    onRun <= CP_ON_CYC + 2)
    else $error("cadence on at wrong time");
  cp_fall_a: assert property ($fell(call_progress_out) |-> offRun >= CP_OFF_CYC &&
    offRun <= CP_OFF_CYC + 2)
    else $error("cadence off at wrong time");
  // Main scenarios reached
  valid_seen_c: cover property ($rose(digit_valid));
  tone_seen_c: cover property ($rose(toneActive));
  cp_seen_c: cover property ($rose(call_progress_out));
endmodule

// ===== bench/dtmf_transceiver_control_tb.sv
// Self-checking bench for the transceiver control block.
// Assumes short timer parameters; 40 cycles stand for 40 ms.
`timescale 1ns/100ps
module dtmf_transceiver_control_tb;
  localparam int CYC = 40;
  // Digit code by row*4+column
  localparam logic [3:0] KEY [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
    4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce;
  logic [3:0] rowDet;
  logic [3:0] colDet;
  logic bandEnergy;
  wire logic [3:0] gen_code_in;
  wire logic latch;
  wire logic genReset;
  wire logic digit_out_enable_n;
  logic [3:0] rx_code_out;
  logic rxCodeOutEn_n;
  logic digit_valid;
  logic early_detect;
  logic tone_out;
  logic toneActive;
  logic [1:0] toneRowSel;
  logic [1:0] toneColSel;
  logic call_progress_out;
  int badCount = 0;
  int nChecks = 0;
  always #2 clk = ~clk;
  dtmf_transceiver_control #(.TONE_CYC(CYC), .PAUSE_CYC(CYC), .CP_ON_CYC(CYC),
    .CP_OFF_CYC(CYC)) dtmf_transceiver_control_i (.*);
  dial_ctrl dial_ctrl_i (.*);
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // Tone detector levels held for n cycles
  task automatic tone(input logic [3:0] r, input logic [3:0] c, input int n);
    rowDet = r;
    colDet = c;
    repeat (n) @(negedge clk);
  endtask
  task automatic burst(input logic v, input int n);
    bandEnergy = v;
    repeat (n) @(negedge clk);
  endtask
  task automatic closeOut();
    if (badCount == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, well past the expected run
  initial begin
    repeat (30000) @(posedge clk);
    badCount++;
    closeOut();
  end
  initial begin
    ce = 1'b1;
    rowDet = 4'h0;
    colDet = 4'h0;
    bandEnergy = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    chk("active", 4'h0, 4'(toneActive));
    for (int i = 0; i < 16; i++) begin
      tone(4'(1 << (i / 4)), 4'(1 << (i % 4)), 60);
      chk("early", 4'h1, 4'(early_detect));
      chk("valid", 4'h1, 4'(digit_valid));
      chk("code", KEY[i], rx_code_out);
      tone(4'h0, 4'h0, 60);
      chk("valid", 4'h0, 4'(digit_valid));
    end
    tone(4'h1, 4'h1, 20);
    tone(4'h0, 4'h0, 10);
    chk("valid", 4'h0, 4'(digit_valid));
    tone(4'h0, 4'h0, 50);
    tone(4'h2, 4'h4, 60);
    tone(4'h0, 4'h0, 20);
    chk("early", 4'h0, 4'(early_detect));
    tone(4'h2, 4'h4, 30);
    chk("valid", 4'h1, 4'(digit_valid));
    chk("code", 4'h6, rx_code_out);
    tone(4'h0, 4'h0, 60);
    dial_ctrl_i.enable(1'b1);
    chk("pinEn", 4'h1, 4'(rxCodeOutEn_n));
    dial_ctrl_i.enable(1'b0);
    chk("pinEn", 4'h0, 4'(rxCodeOutEn_n));
    for (int i = 0; i < 16; i++) begin
      dial_ctrl_i.dial(KEY[i]);
      chk("active", 4'h1, 4'(toneActive));
      chk("rowSel", 4'(i / 4), 4'(toneRowSel));
      chk("colSel", 4'(i % 4), 4'(toneColSel));
    end
    dial_ctrl_i.hang(1'b1);
    dial_ctrl_i.dial(4'h5);
    chk("active", 4'h0, 4'(toneActive));
    chk("tone", 4'h0, 4'(tone_out));
    dial_ctrl_i.hang(1'b0);
    chk("active", 4'h0, 4'(toneActive));
    dial_ctrl_i.dial(4'h5);
    chk("rowSel", 4'h1, 4'(toneRowSel));
    // Enable low: a long pair and a latch edge must leave no trace
    ce = 1'b0;
    tone(4'h1, 4'h1, 60);
    dial_ctrl_i.dial(4'h1);
    tone(4'h0, 4'h0, 1);
    ce = 1'b1;
    tone(4'h0, 4'h0, 2);
    chk("valid", 4'h0, 4'(digit_valid));
    chk("rowSel", 4'h1, 4'(toneRowSel));
    chk("colSel", 4'h1, 4'(toneColSel));
    burst(1'b1, 10);
    burst(1'b0, 60);
    chk("cp", 4'h0, 4'(call_progress_out));
    for (int k = 0; k < 2; k++) begin
      burst(1'b1, 60);
      burst(1'b0, 20);
      burst(1'b1, 60);
      chk("cp", 4'h1, 4'(call_progress_out));
      burst(1'b0, 100);
      chk("cp", 4'h0, 4'(call_progress_out));
    end
    closeOut();
  end
endmodule
bind dtmf_transceiver_control dtmf_checker #(.TONE_CYC(TONE_CYC), .PAUSE_CYC(PAUSE_CYC),
  .CP_ON_CYC(CP_ON_CYC), .CP_OFF_CYC(CP_OFF_CYC)) dtmf_checker_i (.*);

// ===== hdl/dtmf_transceiver_control.sv
// Digital control of a dual-tone transceiver: receiver timing, generator, call progress.
// Assumes tone detectors upstream give per-row/column levels and band energy, synchronous.
`timescale 1ns/100ps
module dtmf_transceiver_control #(
  parameter bit HAS_EARLY = 1'b1,
  parameter bit HAS_CALL_PROGRESS = 1'b1,
  parameter int TONE_CYC = dtmf_pkg::TONE_DETECT_CYC,
  parameter int PAUSE_CYC = dtmf_pkg::PAUSE_DETECT_CYC,
  parameter int CP_ON_CYC = dtmf_pkg::CP_ON_DETECT_CYC,
  parameter int CP_OFF_CYC = dtmf_pkg::CP_OFF_DETECT_CYC
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Receiver tone detector levels
  input wire logic [3:0] rowDet,
  input wire logic [3:0] colDet,
  // Receiver output enable and outputs
  input wire logic digit_out_enable_n,
  output logic [3:0] rx_code_out,
  output logic rxCodeOutEn_n,
  output logic digit_valid,
  output logic early_detect,
  // Generator control
  input wire logic [3:0] gen_code_in,
  input wire logic latch,
  input wire logic genReset,
  output logic tone_out,
  output logic toneActive,
  output logic [1:0] toneRowSel,
  output logic [1:0] toneColSel,
  // Call progress
  input wire logic bandEnergy,
  output logic call_progress_out
);
  // Map row/column onto the shared digit code
  function automatic logic [3:0] rc_to_code(input logic [1:0] r, input logic [1:0] c);
    logic [3:0] code;
    code = dtmf_pkg::CODE_NONE;
    if (c == 2'h3) begin
      code = 4'hD + {2'h0, r};                 // A B C give D E F; D wraps to zero
    end else if (r == 2'h3) begin
      case (c)
        2'h0: code = dtmf_pkg::CODE_STAR;
        2'h1: code = dtmf_pkg::CODE_ZERO;
        default: code = dtmf_pkg::CODE_HASH;
      endcase
    end else begin
      code = 4'(({2'h0, r} * 4'h3) + {2'h0, c} + 4'h1);
    end
    return code;
  endfunction

  // Inverse of rc_to_code for the generator
  function automatic logic [3:0] code_to_rc(input logic [3:0] code);
    logic [3:0] rc;
    rc = 4'h0;
    if (code >= 4'h1 && code <= 4'h9) begin
      rc = {2'(4'(code - 4'h1) / 4'h3), 2'(4'(code - 4'h1) % 4'h3)};
    end else if (code == dtmf_pkg::CODE_ZERO) begin
      rc = 4'hD;
    end else if (code == dtmf_pkg::CODE_STAR) begin
      rc = 4'hC;
    end else if (code == dtmf_pkg::CODE_HASH) begin
      rc = 4'hE;
    end else begin
      rc = {2'(4'(code - 4'hD)), 2'h3}; // A B C, and 0 selects column 3 row 3
    end
    return rc;
  endfunction

  // One-hot to index; also flags exactly one bit set
  function automatic logic [2:0] onehot_idx(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    case (v)
      4'h1: r = 3'h4;
      4'h2: r = 3'h5;
      4'h4: r = 3'h6;
      4'h8: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // Receiver pair decode
  logic [2:0] rowIdx;
  logic [2:0] colIdx;
  logic pairPresent;   // Exactly one row and one column
  logic [3:0] pairCode;
  assign rowIdx = onehot_idx(rowDet);
  assign colIdx = onehot_idx(colDet);
  assign pairPresent = rowIdx[2] & colIdx[2];
  assign pairCode = rc_to_code(rowIdx[1:0], colIdx[1:0]);

  // Tone duration qualifier
  dur_if toneCh ();
  assign toneCh.raw = pairPresent;
  dur_filter #(.ON_CYC(TONE_CYC), .OFF_CYC(PAUSE_CYC)) toneFilt (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .ch(toneCh)
  );

  // Receiver state: one-hot
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_HOLD = 3'b010,
    RX_PAUSE = 3'b100
  } rx_state_t;
  rx_state_t rxState;
  logic [3:0] heldCode;  // Code captured while the pair is being timed

  // Track code during the pair, publish after qualification
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heldCode <= dtmf_pkg::RX_CODE_RST;
    end else if (ce && pairPresent) begin
      heldCode <= pairCode;
    end
  end

  // Digit publication sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxState <= RX_IDLE;
      rx_code_out <= dtmf_pkg::RX_CODE_RST;
      digit_valid <= 1'b0;
    end else if (ce) begin
      case (rxState)
        RX_IDLE: begin
          if (toneCh.qual) begin
            rx_code_out <= heldCode;
            digit_valid <= 1'b1;
            rxState <= RX_HOLD;
          end
        end
        RX_HOLD: begin
          // Gaps shorter than the pause time never drop qual
          if (!toneCh.qual) begin
            rx_code_out <= dtmf_pkg::RX_CODE_RST;
            digit_valid <= 1'b0;
            rxState <= RX_PAUSE;
          end
        end
        RX_PAUSE: begin
          rxState <= RX_IDLE;
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Readers must gate on digit_valid; code is zero otherwise
  assign rxCodeOutEn_n = digit_out_enable_n;

  // Early flag: raw activity edge sets, raw pause clears
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      early_detect <= 1'b0;
    end else if (ce) begin
      if (!HAS_EARLY) begin
        early_detect <= 1'b0;
      end else if (toneCh.rising) begin
        early_detect <= 1'b1;
      end else if (!pairPresent) begin
        early_detect <= 1'b0;
      end
    end
  end

  // Generator latch edge history
  logic latchDly;
  logic latchFall;
  assign latchFall = latchDly & ~latch;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latchDly <= 1'b0;
    end else if (ce) begin
      latchDly <= latch;
    end
  end

  // Generator capture and enable; reset outranks latch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      toneActive <= 1'b0;
      toneRowSel <= dtmf_pkg::SEL_RST;
      toneColSel <= dtmf_pkg::SEL_RST;
    end else if (ce) begin
      if (genReset) begin
        toneActive <= 1'b0;
      end else if (latchFall) begin
        {toneRowSel, toneColSel} <= code_to_rc(gen_code_in);
        toneActive <= 1'b1;
      end
    end
  end

  // Phase steps per tone; XOR of the two square waves stands in for the analog pair
  localparam longint PH_SCALE = longint'(1) << dtmf_pkg::PHASE_W;
  logic [dtmf_pkg::PHASE_W-1:0] rowStep [4];
  logic [dtmf_pkg::PHASE_W-1:0] colStep [4];
  for (genvar i = 0; i < 4; i++) begin : g_steps
    assign rowStep[i] = dtmf_pkg::PHASE_W'(longint'(dtmf_pkg::ROW_HZ[i]) * PH_SCALE
                        / (longint'(dtmf_pkg::CLK_MHZ) * 1000000));
    assign colStep[i] = dtmf_pkg::PHASE_W'(longint'(dtmf_pkg::COL_HZ[i]) * PH_SCALE
                        / (longint'(dtmf_pkg::CLK_MHZ) * 1000000));
  end

  logic [dtmf_pkg::PHASE_W-1:0] rowPhase;
  logic [dtmf_pkg::PHASE_W-1:0] colPhase;

  // Tone synthesis: phase restarts at zero while silent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rowPhase <= '0;
      colPhase <= '0;
      tone_out <= 1'b0;
    end else if (ce) begin
      if (!toneActive) begin
        rowPhase <= '0;
        colPhase <= '0;
        tone_out <= 1'b0;
      end else begin
        rowPhase <= rowPhase + rowStep[toneRowSel];
        colPhase <= colPhase + colStep[toneColSel];
        tone_out <= rowPhase[dtmf_pkg::PHASE_W-1] ^ colPhase[dtmf_pkg::PHASE_W-1];
      end
    end
  end

  // Call progress cadence qualifier
  dur_if cpCh ();
  assign cpCh.raw = HAS_CALL_PROGRESS & bandEnergy;
  dur_filter #(.ON_CYC(CP_ON_CYC), .OFF_CYC(CP_OFF_CYC)) cpFilt (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .ch(cpCh)
  );

  // Registered cadence output tracks qualified energy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      call_progress_out <= 1'b0;
    end else if (ce) begin
      call_progress_out <= cpCh.qual;
    end
  end
endmodule

// ===== hdl/dur_filter.sv
// Duration qualifier: a level must persist for a set time before the output moves.
// Assumes raw input synchronous to clk; counts are cycles of clk.
`timescale 1ns/100ps
module dur_filter #(
  parameter int ON_CYC = 10000000,
  parameter int OFF_CYC = 10000000
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Channel
  dur_if.filt ch
);
  localparam int CW = $clog2((ON_CYC > OFF_CYC ? ON_CYC : OFF_CYC) + 1);
  localparam logic [CW-1:0] ON_LIM = CW'(ON_CYC - 1);
  localparam logic [CW-1:0] OFF_LIM = CW'(OFF_CYC - 1);

  logic [CW-1:0] cnt; // Cycles the raw level has disagreed with output
  logic qual;         // Qualified level
  logic rawDly;       // Raw delayed by one cycle

  // Disagreement timer: short blips or gaps restart it, so they never pass
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      qual <= 1'b0;
    end else if (ce) begin
      if (ch.raw == qual) begin
        cnt <= '0;
      end else if (!qual && cnt == ON_LIM) begin
        qual <= 1'b1;
        cnt <= '0;
      end else if (qual && cnt == OFF_LIM) begin
        qual <= 1'b0;
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  // Edge history for the start-of-activity pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rawDly <= 1'b0;
    end else if (ce) begin
      rawDly <= ch.raw;
    end
  end

  assign ch.qual = qual;
  assign ch.rising = ch.raw & ~rawDly;
endmodule

// ===== include/dtmf_pkg.sv
// Package for the dual-tone transceiver control block: timing, codes, tone tables.
// Assumes a 250 MHz system clock; all times given in microseconds.
package dtmf_pkg;
  // System clock rate
  localparam int CLK_MHZ = 250;
  // Receiver tone and pause limits (us)
  localparam int TONE_DETECT_US = 40000;
  localparam int TONE_REJECT_US = 20000;
  localparam int PAUSE_DETECT_US = 40000;
  localparam int PAUSE_BRIDGE_US = 20000;
  // Call progress limits (us)
  localparam int CP_ON_DETECT_US = 40000;
  localparam int CP_ON_REJECT_US = 10000;
  localparam int CP_OFF_DETECT_US = 40000;
  localparam int CP_OFF_BRIDGE_US = 20000;
  // Least times round up to whole cycles
  localparam int TONE_DETECT_CYC = TONE_DETECT_US * CLK_MHZ;
  localparam int PAUSE_DETECT_CYC = PAUSE_DETECT_US * CLK_MHZ;
  localparam int CP_ON_DETECT_CYC = CP_ON_DETECT_US * CLK_MHZ;
  localparam int CP_OFF_DETECT_CYC = CP_OFF_DETECT_US * CLK_MHZ;
  // Digit code values
  localparam logic [3:0] CODE_ZERO = 4'hA;
  localparam logic [3:0] CODE_STAR = 4'hB;
  localparam logic [3:0] CODE_HASH = 4'hC;
  localparam logic [3:0] CODE_NONE = 4'h0;
  // Reset values
  localparam logic [3:0] RX_CODE_RST = 4'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  // Low group tones (Hz), row 0..3
  localparam int ROW_HZ [4] = '{697, 770, 852, 941};
  // High group tones (Hz), column 0..3
  localparam int COL_HZ [4] = '{1209, 1336, 1477, 1633};
  // Phase accumulator width of the tone generator
  localparam int PHASE_W = 32;
endpackage

// ===== include/dur_if.sv
// Interface carrying one duration-qualifier channel between top and filter.
// Assumes both ends share clk and resetn.
`timescale 1ns/100ps
interface dur_if;
  logic raw;      // Unfiltered activity level
  logic qual;     // Qualified level
  logic rising;   // Start of raw activity seen
  modport filt(input raw, output qual, output rising);
  modport user(output raw, input qual, input rising);
endinterface
